//--- bench/apc_config_port_tb.sv
/*
 self-checking bench for the configuration port.
 assumes the host model below and pull-ups on the data and init lines.
*/
`timescale 1ns/100ps
module apc_config_port_tb;
   import apc_pkg::*;
   localparam int WC = 20;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hold = 1'b0;
   logic rdy = 1'b0;
   logic err = 1'b0;
   logic done = 1'b0;
   logic [2:0] mode = MODE_PERIPH;
   logic cs_n, cs_h, ws_n, rs_n, drv, oe_n, i_out, i_oe_n, flag, chain;
   logic user, valid, busy, init_w, oe;
   logic [7:0] dout, b_out, data, bus, v;
   logic [2:0] mode_q;
   int n_fail = 0;
   int total_checks = 0;
   int n;
   always #50 clk = ~clk;
   assign bus = !oe_n ? b_out : drv ? dout : 8'hff;
   assign init_w = !i_oe_n ? i_out : !hold;

   apc_host host (.clk(clk), .bus(bus), .oe_n(oe_n), .cs_n(cs_n),
      .cs_h(cs_h), .ws_n(ws_n), .rs_n(rs_n), .drv(drv), .dout(dout));

   apc_config_port #(.WAIT_CYC(WC)) uut (.core_clk(clk), .nrst(nrst),
      .chip_select_active_low(cs_n), .chip_select_active_high(cs_h),
      .write_strobe_n(ws_n), .read_strobe_n(rs_n),
      .config_byte_bus_in(bus), .config_byte_bus_out(b_out),
      .config_byte_bus_oe_n(oe_n), .config_mode_pins(mode),
      .init_in(init_w), .init_out(i_out), .init_oe_n(i_oe_n),
      .config_active_low_flag(flag), .chain_enable(chain),
      .user_io_active(user), .cfg_data(data), .cfg_valid(valid),
      .cfg_ready(rdy), .cfg_error(err), .cfg_done(done),
      .mode_q(mode_q), .busy(busy));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic restart(input logic [2:0] m, input logic h);
      @(posedge clk);
      nrst <= 1'b0;
      mode <= m;
      hold <= h;
      repeat (1) @(posedge clk);
      @(negedge clk);
      chk(flag, 1'b0);
      @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(negedge clk);
      chk(i_oe_n, 1'b0);
   endtask

   task automatic wait_ready(output int c);
      c = 0;
      while (busy !== 1'b0 && c < 300)
      begin
         @(negedge clk);
         c++;
      end
      chk(c < 300, 1'b1);
   endtask

   task automatic pop(input logic [7:0] exp);
      @(negedge clk);
      chk(valid, 1'b1);
      chk(data, exp);
      @(posedge clk);
      rdy <= 1'b1;
      @(posedge clk);
      rdy <= 1'b0;
   endtask

   initial
   begin
      #(3000 * 100);
      n_fail++;
      conclude();
   end

   initial
   begin
      restart(MODE_PERIPH, 1'b1);
      repeat (60) @(negedge clk);
      chk(busy, 1'b1);
      @(posedge clk);
      hold <= 1'b0;
      wait_ready(n);
      chk(mode_q, MODE_PERIPH);
      host.rd(v);
      chk(v, {1'b1, STATUS_FILL});
      host.wr(8'ha1, 1'b1, 1'b0, oe);
      host.wr(8'ha2, 1'b1, 1'b0, oe);
      host.wr(8'ha3, 1'b1, 1'b0, oe);
      host.rd(v);
      chk(v, {1'b0, STATUS_FILL});
      pop(8'ha1);
      pop(8'ha2);
      @(negedge clk);
      chk(valid, 1'b0);
      $display("test load done");
      host.wr(8'h5c, 1'b0, 1'b0, oe);
      chk(valid, 1'b0);
      host.wr(8'h3b, 1'b1, 1'b1, oe);
      chk(oe, 1'b1);
      pop(8'h3b);
      @(posedge clk);
      done <= 1'b1;
      repeat (6) @(negedge clk);
      chk(user, 1'b1);
      chk(flag, 1'b1);
      chk(i_oe_n, 1'b1);
      host.wr(8'h11, 1'b1, 1'b0, oe);
      chk(valid, 1'b0);
      done <= 1'b0;
      $display("test select done");
      for (int i = 0; i < 2; i++)
      begin
         restart(i ? MODE_MASTER_SER : MODE_MASTER_PAR, 1'b0);
         wait_ready(n);
         chk(n >= WC + 10, 1'b1);
         chk(n <= CLEAR_CYC + WC + 4, 1'b1);
         chk(mode_q, i ? MODE_MASTER_SER : MODE_MASTER_PAR);
      end
      $display("test master done");
      restart(MODE_EXPRESS, 1'b0);
      repeat (60) @(negedge clk);
      host.wr(8'h22, 1'b1, 1'b0, oe);
      chk(chain, 1'b1);
      chk(valid, 1'b0);
      host.wr(8'h22, 1'b0, 1'b0, oe);
      chk(chain, 1'b0);
      restart(MODE_PERIPH, 1'b0);
      wait_ready(n);
      @(posedge clk);
      err <= 1'b1;
      @(posedge clk);
      err <= 1'b0;
      repeat (2) @(negedge clk);
      chk(i_oe_n, 1'b0);
      chk(i_out, 1'b0);
      $display("test error done");
      conclude();
   end
endmodule

//--- bench/apc_host.sv
/*
 host model: drives the select, strobe and data pins of the port.
 assumes the bench resolves the shared data bus and calls the tasks.
*/
`timescale 1ns/100ps
module apc_host
(
   input wire logic clk,
   input wire logic [7:0] bus,
   input wire logic oe_n,
   output logic cs_n = 1'b1,
   output logic cs_h = 1'b0,
   output logic ws_n = 1'b1,
   output logic rs_n = 1'b1,
   output logic drv = 1'b0,
   output logic [7:0] dout = 8'h00
);
   // one byte per strobe, held 4 clocks, 4 clocks apart
   task automatic wr(input logic [7:0] b, input logic s, input logic rd,
      output logic oe);
      @(posedge clk);
      cs_n <= 1'b0;
      cs_h <= s;
      ws_n <= 1'b0;
      rs_n <= !rd;
      dout <= b;
      drv <= 1'b1;
      repeat (4) @(posedge clk);
      oe = oe_n;
      cs_n <= 1'b1;
      ws_n <= 1'b1;
      rs_n <= 1'b1;
      drv <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // status poll
   task automatic rd(output logic [7:0] v);
      @(posedge clk);
      cs_n <= 1'b0;
      cs_h <= 1'b1;
      rs_n <= 1'b0;
      repeat (5) @(posedge clk);
      v = bus;
      cs_n <= 1'b1;
      rs_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
endmodule

//--- rtl/apc_config_port.sv
/*
 asynchronous peripheral configuration port with a two-entry byte buffer.
 assumes all host pins are asynchronous and pass two flip-flops; an
 outside consumer drains loaded bytes and reports errors and completion.
*/
`timescale 1ns/100ps
module apc_config_port
#(
   parameter int unsigned WAIT_CYC = apc_pkg::MASTER_WAIT_CYC
)
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic chip_select_active_low,
   input wire logic chip_select_active_high,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic [apc_pkg::BYTE_W-1:0] config_byte_bus_in,
   output logic [apc_pkg::BYTE_W-1:0] config_byte_bus_out,
   output logic config_byte_bus_oe_n,
   input wire logic [2:0] config_mode_pins,
   input wire logic init_in,
   output logic init_out,
   output logic init_oe_n,
   output logic config_active_low_flag,
   output logic chain_enable,
   output logic user_io_active,
   output logic [apc_pkg::BYTE_W-1:0] cfg_data,
   output logic cfg_valid,
   input wire logic cfg_ready,
   input wire logic cfg_error,
   input wire logic cfg_done,
   output logic [2:0] mode_q,
   output logic busy
);
   import apc_pkg::*;

   if (WAIT_CYC < 1
      || WAIT_CYC > MASTER_WAIT_MAX_US * (CLK_HZ / 1_000_000))
   begin
      $error("WAIT_CYC must lie between one and the longest master wait");
   end

   localparam logic [15:0] WAIT_LAST = 16'(WAIT_CYC - 1);
   localparam logic [15:0] CLEAR_LAST = 16'(CLEAR_CYC - 1);

   logic [4:0] s1_q;
   logic [4:0] s2_q;
   logic [BYTE_W-1:0] d1_q;
   logic [BYTE_W-1:0] d2_q;
   logic [2:0] m1_q;
   logic [2:0] m2_q;
   apc_state_t state_q;
   logic [15:0] cnt_q;
   logic ws_prev_q;
   logic [BYTE_W-1:0] buf_q [2];
   logic [1:0] cnt_buf_q;
   logic rd_ptr_q;
   logic wr_ptr_q;

   // two-flop synchronisers for all pins
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         s1_q <= 5'h1d;
         s2_q <= 5'h1d;
         d1_q <= 8'h00;
         d2_q <= 8'h00;
         m1_q <= 3'h0;
         m2_q <= 3'h0;
      end
      else
      begin
         s1_q <= {init_in, read_strobe_n, write_strobe_n,
                  chip_select_active_high, chip_select_active_low};
         s2_q <= s1_q;
         d1_q <= config_byte_bus_in;
         d2_q <= d1_q;
         m1_q <= config_mode_pins;
         m2_q <= m1_q;
      end
   end

   wire init_hi = s2_q[4];
   wire rs_n = s2_q[3];
   wire ws_n = s2_q[2];
   wire cs1 = s2_q[1];
   wire cs0_n = s2_q[0];
   wire cfg_phase = (state_q != APC_USER);
   wire express = (mode_q == MODE_EXPRESS);
   wire selected = cfg_phase && !cs0_n && cs1 && !express;
   wire ws_act = selected && !ws_n;
   wire ws_fall = ws_act && !ws_prev_q;
   wire buf_full = (cnt_buf_q == 2'h2);
   wire in_take = ws_fall && (state_q == APC_LOAD) && !buf_full;
   wire out_take = cfg_valid && cfg_ready;
   wire init_pull = (state_q == APC_CLEAR)
      || (state_q == APC_ERROR);

   // configuration sequence
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         state_q <= APC_CLEAR;
         cnt_q <= 16'h0000;
         mode_q <= 3'h0;
      end
      else
      begin
         case (state_q)
            APC_CLEAR:
            begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == CLEAR_LAST)
               begin
                  state_q <= APC_WAIT;
                  cnt_q <= 16'h0000;
               end
            end
            APC_WAIT:
            begin
               if (init_hi)
               begin
                  mode_q <= m2_q;
                  if (m2_q == MODE_MASTER_PAR || m2_q == MODE_MASTER_SER)
                     state_q <= APC_MWAIT;
                  else
                     state_q <= APC_LOAD;
               end
            end
            APC_MWAIT:
            begin
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == WAIT_LAST)
                  state_q <= APC_LOAD;
            end
            APC_LOAD:
            begin
               if (cfg_error)
                  state_q <= APC_ERROR;
               else if (cfg_done && cnt_buf_q == 2'h0)
                  state_q <= APC_USER;
            end
            APC_ERROR:
               state_q <= APC_ERROR;
            default:
               state_q <= APC_USER;
         endcase
      end
   end

   // write strobe edge history
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         ws_prev_q <= 1'b0;
      else
         ws_prev_q <= ws_act;
   end

   // two-entry byte buffer
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         cnt_buf_q <= 2'h0;
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
         buf_q[0] <= 8'h00;
         buf_q[1] <= 8'h00;
      end
      else
      begin
         if (in_take)
         begin
            buf_q[wr_ptr_q] <= d2_q;
            wr_ptr_q <= !wr_ptr_q;
         end
         if (out_take)
            rd_ptr_q <= !rd_ptr_q;
         cnt_buf_q <= cnt_buf_q + 2'(in_take) - 2'(out_take);
      end
   end

   assign cfg_valid = (cnt_buf_q != 2'h0);
   assign cfg_data = buf_q[rd_ptr_q];
   assign busy = buf_full || (state_q != APC_LOAD);

   // status read path; write overrides read
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         config_byte_bus_out <= 8'hff;
         config_byte_bus_oe_n <= 1'b1;
      end
      else
      begin
         config_byte_bus_out <= {!busy, STATUS_FILL};
         config_byte_bus_oe_n <= !(selected && !rs_n && ws_n);
      end
   end

   // init open-drain, configuration flag and chain enable
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         init_oe_n <= 1'b0;
         config_active_low_flag <= 1'b0;
         chain_enable <= 1'b0;
         user_io_active <= 1'b0;
      end
      else
      begin
         init_oe_n <= !init_pull;
         config_active_low_flag <= !cfg_phase;
         chain_enable <= cfg_phase && express && cs1;
         user_io_active <= !cfg_phase;
      end
   end

   assign init_out = 1'b0;

   chk_clear_drives_init: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q == APC_CLEAR) |=> !init_oe_n)
      else $error("init not driven during clear");
   chk_error_drives_init: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q == APC_LOAD && cfg_error) |=> ##1 !init_oe_n)
      else $error("error not signalled on init");
   chk_wait_holds_low: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q == APC_WAIT && !init_hi) |=> state_q == APC_WAIT)
      else $error("left wait while init low");
   chk_master_wait_len: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q == APC_MWAIT && cnt_q != WAIT_LAST) |=> state_q == APC_MWAIT)
      else $error("master wait too short");
   chk_master_wait_entry: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q == APC_WAIT && init_hi && (m2_q == MODE_MASTER_PAR
         || m2_q == MODE_MASTER_SER)) |=> state_q == APC_MWAIT
         && cnt_q == 16'h0000)
      else $error("master wait not started from zero");
   chk_flag_low_config: assert property (
      @(posedge core_clk) disable iff (!nrst)
      cfg_phase && $past(cfg_phase) |-> !config_active_low_flag)
      else $error("flag high during configuration");
   chk_status_byte: assert property (
      @(posedge core_clk) disable iff (!nrst)
      !config_byte_bus_oe_n |-> config_byte_bus_out[6:0] == STATUS_FILL)
      else $error("status low bits not high");
   chk_write_wins: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (selected && !ws_n) |=> config_byte_bus_oe_n)
      else $error("read driven during write");
   chk_capture_byte: assert property (
      @(posedge core_clk) disable iff (!nrst)
      in_take |=> cnt_buf_q == $past(cnt_buf_q) + 2'(!$past(out_take)))
      else $error("write byte not captured");
   chk_user_release: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q == APC_USER) |=> user_io_active && init_oe_n)
      else $error("pins not released after configuration");
   chk_chain_enable: assert property (
      @(posedge core_clk) disable iff (!nrst)
      chain_enable |-> express && $past(cs1))
      else $error("chain enable without express select");
   chk_mode_sampled: assert property (
      @(posedge core_clk) disable iff (!nrst)
      (state_q == APC_WAIT && init_hi) |=> mode_q == $past(m2_q))
      else $error("mode not sampled");
endmodule

//--- rtl/apc_pkg.sv
/*
 constants and types for the asynchronous peripheral configuration port.
 assumes a single 10 mhz core clock and a synchronous active-low reset.
*/
// Operation
// - the config flag is held low until user i/o goes active.
// - init is pulled low while power settles and memory clears.
// - while init is held low from outside, configuration waits.
// - a master waits a further 30 to 300 us after init goes high.
// - a data error during loading is signalled by driving init low.
// - once user i/o is active, init carries no configuration signal.
// - selected only while the low select is low and the high one high.
// - a low write strobe while selected captures the data byte.
// - a selected read shows ready(1)/busy(0) on bit 7, bits 0-6 high.
// - when both strobes are low the write wins and the read is ignored.
// - in express mode the high select is the daisy-chain enable.
// - after configuration the select and strobe pins become user i/o.
// - the mode pins, sampled after init goes high, choose the mode.
// - in parallel modes bytes arrive on the eight data pins.
package apc_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned MASTER_WAIT_MIN_US = 30;
   localparam int unsigned MASTER_WAIT_MAX_US = 300;
   // least time; cycles per microsecond round down
   localparam int unsigned MASTER_WAIT_CYC =
      (MASTER_WAIT_MIN_US * (CLK_HZ / 1_000_000));
   localparam int unsigned CLEAR_CYC = 16;
   localparam int unsigned BYTE_W = 8;
   localparam logic [2:0] MODE_EXPRESS = 3'h6;
   localparam logic [2:0] MODE_PERIPH = 3'h5;
   localparam logic [2:0] MODE_MASTER_PAR = 3'h3;
   localparam logic [2:0] MODE_MASTER_SER = 3'h0;
   localparam logic [6:0] STATUS_FILL = 7'h7f;

   typedef enum logic [2:0] {
      APC_CLEAR = 3'b000,
      APC_WAIT = 3'b001,
      APC_MWAIT = 3'b010,
      APC_LOAD = 3'b011,
      APC_ERROR = 3'b100,
      APC_USER = 3'b101
   } apc_state_t;
endpackage
